// file: core/acp_top.v
// converter control and sample packetiser with register port
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "acp_map.vh"
module acp_top (
  input wire clk,
  input wire srst,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire trig_pin,
  output reg conv_enable,
  output reg conv_ref_sel,
  output reg conv_cal_pulse,
  output reg conv_start,
  output reg [2:0] conv_chan,
  input wire conv_done,
  input wire [11:0] conv_data,
  output wire pkt_valid,
  input wire pkt_ready,
  output reg [7:0] pkt_data,
  output wire pkt_eop,
  output reg [23:0] pkt_dest
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SCAN = 3'h1;
  localparam ST_CONV = 3'h2;
  localparam ST_SEND = 3'h3;
  localparam ST_EOP = 3'h4;
  localparam ST_CLOSE = 3'h5;

  reg [23:0] dest_reg [0:7];
  reg [7:0] in_en_reg;
  reg drop_reg;
  reg [1:0] width_reg;
  reg [7:0] spp_reg;
  reg cal_reg;
  reg [2:0] warm_reg;
  reg [7:0] open_reg;
  reg [7:0] cnt_reg [0:7];
  reg close_pend_reg;
  reg close_mode_reg;
  reg [2:0] state_reg;
  reg [2:0] idx_reg;
  reg [31:0] shift_reg;
  reg [2:0] left_reg;
  wire trig_pulse;
  wire [31:0] fmt_word;
  wire [2:0] fmt_bytes;
  wire [3:0] sel_word;
  wire sel_input;
  wire sel_general;
  wire acc_mapped;
  wire warm_done;
  wire drop_event;
  wire [7:0] cnt_inc;
  integer i;
  integer j;

  acp_trig_sync u_sync (
    .clk(clk),
    .srst(srst),
    .trig_pin(trig_pin),
    .trig_pulse(trig_pulse)
  );

  acp_format u_fmt (
    .raw(conv_data),
    .width(width_reg),
    .word(fmt_word),
    .nbytes(fmt_bytes)
  );

  assign sel_word = reg_addr[5:2];
  assign sel_input = (reg_addr[1:0] == 2'h0) && (reg_addr <= `ACP_OFS_INPUT7);
  assign sel_general = (reg_addr == `ACP_OFS_GENERAL);
  assign acc_mapped = (reg_wr | reg_rd) & (sel_input | sel_general);
  assign warm_done = (warm_reg == `ACP_WARMUP_PULSES);
  assign drop_event = trig_pulse & conv_enable & warm_done & (state_reg != ST_IDLE);
  assign cnt_inc = cnt_reg[idx_reg] + 8'h01;

  assign pkt_valid = (state_reg == ST_SEND) || (state_reg == ST_EOP);
  assign pkt_eop = (state_reg == ST_EOP);

  // register writes
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < `ACP_NUM_INPUTS; i = i + 1) begin
        dest_reg[i] <= `ACP_RST_DEST;
      end
      in_en_reg <= {8{`ACP_RST_IN_EN}};
      width_reg <= `ACP_RST_WIDTH;
      spp_reg <= `ACP_RST_SPP;
      cal_reg <= `ACP_RST_CAL;
      conv_enable <= `ACP_RST_EN;
    end else if (reg_wr) begin
      if (sel_input && !conv_enable) begin
        dest_reg[sel_word[2:0]] <= reg_wdata[`ACP_IN_DEST_HI:`ACP_IN_DEST_LO];
        in_en_reg[sel_word[2:0]] <= reg_wdata[`ACP_IN_EN_BIT];
      end
      if (sel_general) begin
        width_reg <= reg_wdata[`ACP_GC_WIDTH_HI:`ACP_GC_WIDTH_LO];
        spp_reg <= reg_wdata[`ACP_GC_SPP_HI:`ACP_GC_SPP_LO];
        cal_reg <= reg_wdata[`ACP_GC_CAL_BIT];
        conv_enable <= reg_wdata[`ACP_GC_EN_BIT];
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      conv_ref_sel <= `ACP_RST_CAL;
    end else begin
      conv_ref_sel <= cal_reg;
    end
  end

  // register reads, one cycle later
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd && sel_input) begin
        reg_rdata <= {dest_reg[sel_word[2:0]], 7'h00, in_en_reg[sel_word[2:0]]};
      end else if (reg_rd && sel_general) begin
        reg_rdata <= {7'h00, drop_reg, 6'h00, width_reg, spp_reg, 6'h00, cal_reg,
                      conv_enable};
      end
    end
  end

  // sticky drop flag, set beats read clear
  always @(posedge clk) begin
    if (srst) begin
      drop_reg <= `ACP_RST_DROP;
    end else if (drop_event) begin
      drop_reg <= 1'b1;
    end else if (reg_rd && sel_general) begin
      drop_reg <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      warm_reg <= 3'h0;
      conv_cal_pulse <= 1'b0;
    end else begin
      conv_cal_pulse <= 1'b0;
      if (!conv_enable) begin
        warm_reg <= 3'h0;
      end else if (trig_pulse && !warm_done) begin
        warm_reg <= warm_reg + 3'h1;
        conv_cal_pulse <= 1'b1;
      end
    end
  end

  // any access to a mapped register closes open packets
  always @(posedge clk) begin
    if (srst) begin
      close_pend_reg <= 1'b0;
    end else if (acc_mapped) begin
      close_pend_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && !(trig_pulse && conv_enable && warm_done)) begin
      close_pend_reg <= 1'b0;
    end
  end

  // sequencer: scan inputs, convert, send bytes, end packets
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      idx_reg <= 3'h0;
      shift_reg <= 32'h00000000;
      left_reg <= 3'h0;
      open_reg <= 8'h00;
      close_mode_reg <= 1'b0;
      conv_start <= 1'b0;
      conv_chan <= 3'h0;
      pkt_data <= 8'h00;
      pkt_dest <= 24'h000000;
      for (j = 0; j < `ACP_NUM_INPUTS; j = j + 1) begin
        cnt_reg[j] <= 8'h00;
      end
    end else begin
      conv_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= 3'h0;
          // deliver once calibration pulses are done
          if (trig_pulse && conv_enable && warm_done) begin
            state_reg <= ST_SCAN;
          end else if (close_pend_reg && (open_reg != 8'h00)) begin
            close_mode_reg <= 1'b1;
            state_reg <= ST_CLOSE;
          end
        end
        ST_SCAN: begin
          if (in_en_reg[idx_reg]) begin
            conv_start <= 1'b1;
            conv_chan <= idx_reg;
            pkt_dest <= dest_reg[idx_reg];
            state_reg <= ST_CONV;
          end else if (idx_reg == 3'h7) begin
            state_reg <= ST_IDLE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            shift_reg <= {fmt_word[23:0], 8'h00};
            pkt_data <= fmt_word[31:24];
            left_reg <= fmt_bytes;
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (pkt_ready) begin
            pkt_data <= shift_reg[31:24];
            shift_reg <= {shift_reg[23:0], 8'h00};
            left_reg <= left_reg - 3'h1;
            if (left_reg == 3'h1) begin
              if ((spp_reg != 8'h00) && (cnt_inc == spp_reg)) begin
                cnt_reg[idx_reg] <= 8'h00;
                state_reg <= ST_EOP;
              end else begin
                cnt_reg[idx_reg] <= cnt_inc;
                open_reg[idx_reg] <= 1'b1;
                state_reg <= (idx_reg == 3'h7) ? ST_IDLE : ST_SCAN;
                idx_reg <= idx_reg + 3'h1;
              end
            end
          end
        end
        ST_EOP: begin
          if (pkt_ready) begin
            open_reg[idx_reg] <= 1'b0;
            cnt_reg[idx_reg] <= 8'h00;
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == 3'h7) begin
              close_mode_reg <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= close_mode_reg ? ST_CLOSE : ST_SCAN;
            end
          end
        end
        ST_CLOSE: begin
          if (open_reg[idx_reg]) begin
            pkt_dest <= dest_reg[idx_reg];
            state_reg <= ST_EOP;
          end else if (idx_reg == 3'h7) begin
            close_mode_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: core/acp_map.vh
// register offsets, fields, reset values and counts of the sample packetiser
`ifndef ACP_MAP_VH
`define ACP_MAP_VH

`define ACP_OFS_INPUT0 6'h00
`define ACP_OFS_INPUT7 6'h1c
`define ACP_OFS_GENERAL 6'h20
`define ACP_NUM_INPUTS 8

`define ACP_IN_DEST_HI 31
`define ACP_IN_DEST_LO 8
`define ACP_IN_EN_BIT 0

`define ACP_GC_DROP_BIT 24
`define ACP_GC_WIDTH_HI 17
`define ACP_GC_WIDTH_LO 16
`define ACP_GC_SPP_HI 15
`define ACP_GC_SPP_LO 8
`define ACP_GC_CAL_BIT 1
`define ACP_GC_EN_BIT 0

`define ACP_RST_DEST 24'h000000
`define ACP_RST_IN_EN 1'b0
`define ACP_RST_DROP 1'b1
`define ACP_RST_WIDTH 2'h1
`define ACP_RST_SPP 8'h01
`define ACP_RST_CAL 1'b0
`define ACP_RST_EN 1'b0

`define ACP_WIDTH_8 2'h0
`define ACP_WIDTH_16 2'h1
`define ACP_WIDTH_RSVD 2'h2
`define ACP_WIDTH_32 2'h3

`define ACP_WARMUP_PULSES 3'h6

`endif

// file: core/acp_trig_sync.v
// three-stage synchroniser and rising-edge detector for the trigger pin
`timescale 1ns/10ps
`default_nettype none
module acp_trig_sync (
  input wire clk,
  input wire srst,
  input wire trig_pin,
  output reg trig_pulse
);
  reg meta_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg level_reg;

  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
      trig_pulse <= 1'b0;
    end else begin
      meta_reg <= trig_pin;
      sync2_reg <= meta_reg;
      sync3_reg <= sync2_reg;
      trig_pulse <= 1'b0;
      // accept a change only once the two settled stages agree
      if (sync2_reg == sync3_reg) begin
        level_reg <= sync3_reg;
        trig_pulse <= sync3_reg & ~level_reg;
      end
    end
  end
endmodule
`default_nettype wire

// file: core/acp_format.v
// left-aligned sample formatter: raw 12-bit value to byte-serial word
`timescale 1ns/10ps
`default_nettype none
`include "acp_map.vh"
module acp_format (
  input wire [11:0] raw,
  input wire [1:0] width,
  output reg [31:0] word,
  output reg [2:0] nbytes
);
  always @* begin
    word = 32'h00000000;
    nbytes = 3'h2;
    case (width)
      `ACP_WIDTH_8: begin
        word = {raw[11:4], 24'h000000};
        nbytes = 3'h1;
      end
      `ACP_WIDTH_32: begin
        word = {raw, 20'h00000};
        nbytes = 3'h4;
      end
      default: begin
        word = {raw, 4'h0, 16'h0000};
        nbytes = 3'h2;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: bench/acp_assertions.sv
// port-level property checker for the sample packetiser
`timescale 1ns/10ps
`default_nettype none
module acp_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic conv_enable,
  input wire logic conv_cal_pulse,
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire logic conv_done,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_eop,
  input wire logic [23:0] pkt_dest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_gen_wr;
    reg_wr && reg_addr == 6'h20;
  endsequence
  sequence s_gen_rd;
    reg_rd && reg_addr == 6'h20;
  endsequence
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  // drop bit masked out: it may set between write and read
  property p_gen_back;
    s_gen_wr ##2 s_gen_rd |=> (reg_rdata & 32'h0003ff03) == ($past(reg_wdata, 3) & 32'h0003ff03);
  endproperty
  a_gen_back: assert property (p_gen_back) else $error("general fields not read back");
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_en;
    conv_start || conv_cal_pulse |-> conv_enable && !(conv_start && conv_cal_pulse);
  endproperty
  a_start_en: assert property (p_start_en) else $error("conversion while disabled");
  // one end token per packet, nothing offered right after it
  property p_eop_valid;
    pkt_eop && pkt_ready |=> !pkt_valid;
  endproperty
  a_eop_valid: assert property (p_eop_valid) else $error("offer right after end token");
  property p_hold;
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_eop) && $stable(pkt_dest)
      && (pkt_eop || $stable(pkt_data));
  endproperty
  a_hold: assert property (p_hold) else $error("offered byte changed before accept");
  property p_chan;
    conv_start |=> $stable(conv_chan) [*2];
  endproperty
  a_chan: assert property (p_chan) else $error("channel moved during conversion");
  property p_done_byte;
    conv_done |=> pkt_valid && !pkt_eop;
  endproperty
  a_done_byte: assert property (p_done_byte) else $error("no byte after conversion");
endmodule
bind acp_top acp_assertions u_chk (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_enable(conv_enable),
  .conv_cal_pulse(conv_cal_pulse), .conv_start(conv_start), .conv_chan(conv_chan),
  .conv_done(conv_done), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
  .pkt_data(pkt_data), .pkt_eop(pkt_eop), .pkt_dest(pkt_dest)
);
`default_nettype wire

// file: bench/acp_far_model.sv
// converter and endpoint model facing the packetiser
`timescale 1ns/10ps
`default_nettype none
module acp_far_model #(
  parameter logic [11:0] VAL = 12'hab5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic conv_start,
  input wire logic stall,
  input wire logic slow,
  output logic conv_done,
  output logic [11:0] conv_data,
  output logic pkt_ready
);
  logic [2:0] dly;
  always @(posedge clk) begin
    if (srst) begin
      dly <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h0;
      pkt_ready <= 1'b0;
    end else begin
      dly <= {dly[1:0], conv_start};
      conv_done <= slow ? dly[2] : dly[0];
      // data scrambled outside done so stale values never pass
      conv_data <= (slow ? dly[2] : dly[0]) ? VAL : ~conv_data;
      pkt_ready <= !stall && (!slow || !pkt_ready);
    end
  end
endmodule
`default_nettype wire

// file: bench/acp_top_tb_top.sv
// self-checking bench for the sample packetiser
`timescale 1ns/10ps
`default_nettype none
module acp_top_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] reg_addr = 6'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trig_pin = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic conv_enable, conv_ref_sel, conv_cal_pulse, conv_start, conv_done;
  wire logic [2:0] conv_chan;
  wire logic [11:0] conv_data;
  wire logic pkt_valid, pkt_ready, pkt_eop;
  wire logic [7:0] pkt_data;
  wire logic [23:0] pkt_dest;
  int miscompares = 0;
  int comparisons = 0;
  logic [32:0] got_q[$];
  logic [32:0] exp_q[$];
  logic [1:0] wl [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int nb [4] = '{1, 2, 4, 2};
  logic [5:0] chan_pair = 6'h0;
  int cal_n = 0;
  localparam logic [31:0] SW = {12'hab5, 20'h0};
  acp_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_pin(trig_pin),
    .conv_enable(conv_enable), .conv_ref_sel(conv_ref_sel), .conv_cal_pulse(conv_cal_pulse),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_data(conv_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_data(pkt_data), .pkt_eop(pkt_eop), .pkt_dest(pkt_dest));
  acp_far_model u_far (.clk(clk), .srst(srst), .conv_start(conv_start), .stall(stall),
    .slow(slow), .conv_done(conv_done), .conv_data(conv_data), .pkt_ready(pkt_ready));
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (!srst && pkt_valid === 1'b1 && pkt_ready === 1'b1)
      got_q.push_back({pkt_dest, pkt_eop, pkt_eop ? 8'h0 : pkt_data});
  // last two converted channels and the calibration pulse count
  always @(posedge clk) begin
    if (!srst && conv_start === 1'b1)
      chan_pair <= {chan_pair[2:0], conv_chan};
    if (!srst && conv_cal_pulse === 1'b1)
      cal_n <= cal_n + 1;
  end
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", {1'b0, e}, {1'b0, reg_rdata});
  endtask
  // pin held past the synchroniser, then time to drain
  task automatic trig(input int n);
    repeat (n) begin
      @(posedge clk);
      trig_pin <= 1'b1;
      repeat (4) @(posedge clk);
      trig_pin <= 1'b0;
      repeat (60) @(posedge clk);
    end
  endtask
  task automatic expect_pkt(input logic [23:0] d, input int n, input bit eop);
    for (int i = 0; i < n; i++)
      exp_q.push_back({d, 1'b0, SW[31-8*i -: 8]});
    if (eop)
      exp_q.push_back({d, 1'b1, 8'h0});
  endtask
  task automatic cmpq;
    chk("item count", 33'(exp_q.size()), 33'(got_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        chk("stream item", exp_q[i], got_q[i]);
    got_q.delete();
    exp_q.delete();
  endtask
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(6'h20, 32'h01010100);
    rd(6'h20, 32'h00010100);
    rd(6'h1c, 32'h0);
    wr(6'h0c, 32'habcdefff);
    wr(6'h14, 32'h12345601);
    rd(6'h0c, 32'habcdef01);
    rd(6'h24, 32'h0);
    // last pass uses the reserved width code, sent as 16-bit
    foreach (wl[k]) begin
      wr(6'h20, {14'h0, wl[k], 16'h0100});
      slow <= (k == 2);
      wr(6'h20, {14'h0, wl[k], 16'h0101});
      trig(6);
      cmpq;
      chk("cal pulses", 33'(6 * (k + 1)), 33'(cal_n));
      trig(1);
      expect_pkt(24'habcdef, nb[k], 1'b1);
      expect_pkt(24'h123456, nb[k], 1'b1);
      cmpq;
      chk("conv_chan", 33'h1d, {27'h0, chan_pair});
    end
    wr(6'h0c, 32'h0);
    slow <= 1'b0;
    rd(6'h0c, 32'habcdef01);
    wr(6'h20, 32'h00010103);
    rd(6'h20, 32'h00010103);
    chk("conv_ref_sel", 33'h1, {32'h0, conv_ref_sel});
    trig(1);
    // first sample after entering calibration is unreliable
    got_q.delete();
    stall <= 1'b1;
    trig(2);
    rd(6'h20, 32'h01010103);
    stall <= 1'b0;
    repeat (80) @(posedge clk);
    expect_pkt(24'habcdef, 2, 1'b1);
    expect_pkt(24'h123456, 2, 1'b1);
    cmpq;
    wr(6'h20, 32'h00000003);
    trig(2);
    repeat (2) begin
      expect_pkt(24'habcdef, 1, 1'b0);
      expect_pkt(24'h123456, 1, 1'b0);
    end
    cmpq;
    rd(6'h20, 32'h00000003);
    repeat (20) @(posedge clk);
    expect_pkt(24'habcdef, 0, 1'b1);
    expect_pkt(24'h123456, 0, 1'b1);
    cmpq;
    // mid-run reset brings every register back to its reset value
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd(6'h20, 32'h01010100);
    rd(6'h0c, 32'h0);
    chk("conv_ref_sel", 33'h0, {32'h0, conv_ref_sel});
    final_report;
  end
endmodule
`default_nettype wire
